/* File: shared/mcd_defs.vh */
// Constants for the core data memory, stack and flag block
`ifndef MCD_DEFS_VH
`define MCD_DEFS_VH
`define MCD_ADDR_IND0 8'h00
`define MCD_ADDR_PTR0 8'h01
`define MCD_ADDR_IND1 8'h02
`define MCD_ADDR_PTR1 8'h03
`define MCD_ADDR_BANK 8'h04
`define MCD_ADDR_ACC 8'h05
`define MCD_ADDR_PCL 8'h06
`define MCD_ADDR_TBLPTR 8'h07
`define MCD_ADDR_TBLHI 8'h08
`define MCD_ADDR_FLAGS 8'h0a
`define MCD_ADDR_GP_BASE 8'h60
`define MCD_ADDR_SHARED_TOP 8'h40
`define MCD_ZERO_BYTE 8'h00
`define MCD_FLAG_C 0
`define MCD_FLAG_AC 1
`define MCD_FLAG_Z 2
`define MCD_FLAG_OV 3
`define MCD_FLAG_PDF 4
`define MCD_FLAG_TO 5
`define MCD_FLAG_WMASK 8'h0f
`define MCD_STACK_DEPTH 8
`define MCD_PC_W 12
// ALU operation codes
`define MCD_OP_ADD 4'h0
`define MCD_OP_ADC 4'h1
`define MCD_OP_SUB 4'h2
`define MCD_OP_SBC 4'h3
`define MCD_OP_DAA 4'h4
`define MCD_OP_AND 4'h5
`define MCD_OP_OR 4'h6
`define MCD_OP_XOR 4'h7
`define MCD_OP_CPL 4'h8
`define MCD_OP_RL 4'h9
`define MCD_OP_RR 4'ha
`define MCD_OP_RLC 4'hb
`define MCD_OP_RRC 4'hc
`define MCD_OP_INC 4'hd
`define MCD_OP_DEC 4'he
`define MCD_OP_PASS 4'hf
// Software command register (word index 0x40 on the bus)
`define MCD_BUS_CMD 8'h40
`define MCD_BUS_PC 8'h41
`define MCD_BUS_STAT 8'h42
`define MCD_BUS_TBLADDR 8'h43
`define MCD_BUS_ALU 8'h44
`define MCD_BUS_ERR_DATA 32'hdead_beef
`define MCD_CMD_CALL 4'h1
`define MCD_CMD_RET 4'h2
`define MCD_CMD_INTERRUPT_RETURN 4'h3
`define MCD_CMD_IRQ 4'h4
`define MCD_CMD_HALT 4'h5
`define MCD_CMD_WDTCLR 4'h6
`define MCD_CMD_WDTOUT 4'h7
`define MCD_CMD_TBLC 4'h8
`define MCD_CMD_TBLL 4'h9
`define MCD_CMD_BITSET 4'ha
`define MCD_CMD_BITCLR 4'hb
`define MCD_CMD_ALU 4'hc
`define MCD_CMD_MOVTO 4'hd
`define MCD_CMD_MOVFROM 4'he
`endif

/* File: design/mcd_stack.v */
// Eight-level return-address stack
`timescale 1ns/10ps
module mcd_stack #(
	parameter DEPTH = 8,
	parameter PCW = 12
) (
	input wire clk_sys,
	input wire rst_n,
	input wire push,
	input wire pop,
	input wire [PCW-1:0] push_pc,
	output wire [PCW-1:0] top_pc,
	output wire full,
	output reg [3:0] level
);
	localparam [3:0] DEPTH_L = DEPTH;
	reg [PCW-1:0] mem [0:DEPTH-1];
	integer i;
	// Level counts stored entries; 0 is the empty top after reset
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			level <= 4'h0;
		end else if (push && !full) begin
			level <= level + 4'h1;
		end else if (pop && level != 4'h0) begin
			level <= level - 4'h1;
		end
	end
	// Shift register: entry 0 is newest, so overflow simply drops the oldest
	always @(posedge clk_sys) begin
		if (push) begin
			mem[0] <= push_pc;
			for (i = 1; i < DEPTH; i = i + 1) begin
				mem[i] <= mem[i-1];
			end
		end else if (pop) begin
			for (i = 0; i < DEPTH - 1; i = i + 1) begin
				mem[i] <= mem[i+1];
			end
		end
	end
	assign top_pc = mem[0];
	assign full = (level == DEPTH_L);
endmodule

/* File: design/mcd_alu.v */
// 8-bit arithmetic and logic unit with flag outputs
`timescale 1ns/10ps
`include "mcd_defs.vh"
module mcd_alu (
	input wire [3:0] op,
	input wire [7:0] a,
	input wire [7:0] b,
	input wire cin,
	input wire acin,
	output reg [7:0] res,
	output reg c_out,
	output reg ac_out,
	output reg ov_out,
	output wire z_out
);
	reg [8:0] s;
	reg [4:0] lo;
	reg [7:0] bb;
	reg cc;
	reg [8:0] adj;
	// Subtraction is a + ~b + 1, so carry means no borrow
	always @* begin
		s = 9'h000;
		lo = 5'h00;
		bb = b;
		cc = 1'b0;
		adj = 9'h000;
		res = a;
		c_out = cin;
		ac_out = acin;
		ov_out = 1'b0;
		case (op)
			`MCD_OP_ADD, `MCD_OP_ADC, `MCD_OP_SUB, `MCD_OP_SBC: begin
				bb = (op == `MCD_OP_SUB || op == `MCD_OP_SBC) ? ~b : b;
				cc = (op == `MCD_OP_ADD) ? 1'b0 : (op == `MCD_OP_SUB) ? 1'b1 : cin;
				s = {1'b0, a} + {1'b0, bb} + {8'h00, cc};
				lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cc};
				res = s[7:0];
				c_out = s[8];
				ac_out = lo[4];
				ov_out = (a[7] == bb[7]) && (s[7] != a[7]);
			end
			`MCD_OP_DAA: begin
				adj = {1'b0, a};
				if (acin || a[3:0] > 4'h9)
					adj = adj + 9'h006;
				if (cin || adj[7:4] > 4'h9 || adj[8])
					adj = adj + 9'h060;
				res = adj[7:0];
				c_out = cin | adj[8];
			end
			`MCD_OP_AND: res = a & b;
			`MCD_OP_OR: res = a | b;
			`MCD_OP_XOR: res = a ^ b;
			`MCD_OP_CPL: res = ~a;
			`MCD_OP_RL: res = {a[6:0], a[7]};
			`MCD_OP_RR: res = {a[0], a[7:1]};
			`MCD_OP_RLC: begin
				res = {a[6:0], cin};
				c_out = a[7];
			end
			`MCD_OP_RRC: begin
				res = {cin, a[7:1]};
				c_out = a[0];
			end
			`MCD_OP_INC: res = a + 8'h01;
			`MCD_OP_DEC: res = a - 8'h01;
			default: res = b;
		endcase
	end
	assign z_out = (res == 8'h00);
endmodule

/* File: design/mcd_core.v */
// Data memory, pointers, flags, stack and table address over Avalon-MM
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
`include "mcd_defs.vh"
module mcd_core (
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output wire waitrequest,
	output reg irq_ack,
	output reg [11:0] table_addr,
	output reg skip
);
	localparam ST_IDLE = 3'b001;
	localparam ST_EXEC = 3'b010;
	localparam ST_DONE = 3'b100;
	reg [2:0] state;
	reg [7:0] ptr0;
	reg [7:0] ptr1;
	reg [7:0] bank;
	reg [7:0] acc;
	reg [11:0] pc;
	reg [7:0] tblptr;
	reg [7:0] tblhi;
	reg [5:0] flags;
	reg irq_pend;
	reg [7:0] ram0 [0:255];
	reg [7:0] lcd [0:255];
	reg [31:0] cmd;
	reg [7:0] sfr_rdata;
	reg [7:0] eff_addr;
	reg eff_null;
	reg eff_lcd;
	reg [7:0] mem_rd;
	wire [3:0] cmd_op = cmd[31:28];
	wire [7:0] cmd_addr = cmd[7:0];
	wire [7:0] cmd_data = cmd[15:8];
	wire [2:0] cmd_bit = cmd[18:16];
	wire [3:0] cmd_alu = cmd[23:20];
	wire cmd_imm = cmd[24];
	wire stk_full;
	wire [3:0] stk_level;
	wire [11:0] stk_top;
	wire stk_push;
	wire stk_pop;
	wire [7:0] alu_b;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_ac;
	wire alu_ov;
	wire alu_z;
	// Indirect ports resolve through their pointer; pointer one may reach the display bank
	always @* begin
		eff_addr = cmd_addr;
		eff_null = 1'b0;
		eff_lcd = 1'b0;
		if (cmd_addr == `MCD_ADDR_IND0 || cmd_addr == `MCD_ADDR_IND1) begin
			eff_addr = (cmd_addr == `MCD_ADDR_IND0) ? ptr0 : ptr1;
			eff_null = (eff_addr == `MCD_ADDR_IND0) || (eff_addr == `MCD_ADDR_IND1);
			eff_lcd = (cmd_addr == `MCD_ADDR_IND1) && (bank == 8'h01)
				&& (eff_addr >= `MCD_ADDR_SHARED_TOP);
		end
	end
	// Special registers; unassigned locations below 60H read as zero
	always @* begin
		case (eff_addr)
			`MCD_ADDR_PTR0: sfr_rdata = ptr0;
			`MCD_ADDR_PTR1: sfr_rdata = ptr1;
			`MCD_ADDR_BANK: sfr_rdata = bank;
			`MCD_ADDR_ACC: sfr_rdata = acc;
			`MCD_ADDR_PCL: sfr_rdata = pc[7:0];
			`MCD_ADDR_TBLPTR: sfr_rdata = tblptr;
			`MCD_ADDR_TBLHI: sfr_rdata = tblhi;
			`MCD_ADDR_FLAGS: sfr_rdata = {2'b00, flags};
			default: sfr_rdata = `MCD_ZERO_BYTE;
		endcase
	end
	// Memory read mux; indirect self-reference returns zero
	always @* begin
		if (eff_null)
			mem_rd = `MCD_ZERO_BYTE;
		else if (eff_lcd)
			mem_rd = lcd[eff_addr];
		else if (eff_addr >= `MCD_ADDR_GP_BASE)
			mem_rd = ram0[eff_addr];
		else
			mem_rd = sfr_rdata;
	end
	assign alu_b = cmd_imm ? cmd_data : mem_rd;
	mcd_alu u_alu (
		.op(cmd_alu),
		.a(acc),
		.b(alu_b),
		.cin(flags[`MCD_FLAG_C]),
		.acin(flags[`MCD_FLAG_AC]),
		.res(alu_res),
		.c_out(alu_c),
		.ac_out(alu_ac),
		.ov_out(alu_ov),
		.z_out(alu_z)
	);
	// Only the program counter goes onto the stack, never the flag word
	assign stk_push = (state == ST_EXEC) && (cmd_op == `MCD_CMD_CALL
		|| (cmd_op == `MCD_CMD_IRQ && !stk_full));
	assign stk_pop = (state == ST_EXEC) && (cmd_op == `MCD_CMD_RET
		|| cmd_op == `MCD_CMD_INTERRUPT_RETURN) && (stk_level != 4'h0);
	mcd_stack #(
		.DEPTH(`MCD_STACK_DEPTH),
		.PCW(`MCD_PC_W)
	) u_stack (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(stk_push),
		.pop(stk_pop),
		.push_pc(pc),
		.top_pc(stk_top),
		.full(stk_full),
		.level(stk_level)
	);
	// Command writes and bus reads finish in one EXEC cycle then release
	assign waitrequest = (read || write) && (state != ST_DONE);
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: if (read || write) state <= ST_EXEC;
				ST_EXEC: state <= ST_DONE;
				ST_DONE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end
	// Command latch, captured when a write to the command word is taken
	always @(posedge clk_sys) begin
		if (!rst_n)
			cmd <= 32'h0000_0000;
		else if (state == ST_IDLE && write && address == `MCD_BUS_CMD)
			cmd <= writedata;
		else if (state == ST_DONE)
			cmd <= 32'h0000_0000;
	end
	// Core execution of one command
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ptr0 <= 8'h00;
			ptr1 <= 8'h00;
			bank <= 8'h00;
			acc <= 8'h00;
			pc <= 12'h000;
			tblptr <= 8'h00;
			tblhi <= 8'h00;
			flags <= 6'h00;
			irq_pend <= 1'b0;
			irq_ack <= 1'b0;
			table_addr <= 12'h000;
			skip <= 1'b0;
		end else begin
			irq_ack <= 1'b0;
			// A pending request is acknowledged once the stack has room
			if (irq_pend && !stk_full && state == ST_IDLE) begin
				irq_pend <= 1'b0;
				irq_ack <= 1'b1;
			end
			if (state == ST_IDLE && write && address != `MCD_BUS_CMD) begin
				if (address == `MCD_BUS_PC)
					pc <= writedata[11:0];
				else if (address == `MCD_BUS_TBLADDR)
					tblhi <= writedata[7:0];
			end
			if (state == ST_EXEC) begin
				case (cmd_op)
					`MCD_CMD_CALL: pc <= cmd[11:0];
					`MCD_CMD_RET, `MCD_CMD_INTERRUPT_RETURN: if (stk_level != 4'h0) pc <= stk_top;
					`MCD_CMD_IRQ: begin
						if (stk_full)
							irq_pend <= 1'b1;
						else begin
							irq_ack <= 1'b1;
							pc <= cmd[11:0];
						end
					end
					`MCD_CMD_HALT: begin
						flags[`MCD_FLAG_PDF] <= 1'b1;
						flags[`MCD_FLAG_TO] <= 1'b0;
					end
					`MCD_CMD_WDTCLR: begin
						flags[`MCD_FLAG_PDF] <= 1'b0;
						flags[`MCD_FLAG_TO] <= 1'b0;
					end
					`MCD_CMD_WDTOUT: flags[`MCD_FLAG_TO] <= 1'b1;
					`MCD_CMD_TBLC: table_addr <= {pc[11:8], tblptr};
					`MCD_CMD_TBLL: table_addr <= {4'hf, tblptr};
					`MCD_CMD_BITSET, `MCD_CMD_BITCLR:
						mem_store(mem_rd | (8'h01 << cmd_bit), mem_rd & ~(8'h01 << cmd_bit));
					`MCD_CMD_ALU: begin
						acc <= alu_res;
						flags[`MCD_FLAG_C] <= alu_c;
						flags[`MCD_FLAG_AC] <= alu_ac;
						flags[`MCD_FLAG_Z] <= alu_z;
						flags[`MCD_FLAG_OV] <= alu_ov;
						skip <= alu_z;
					end
					`MCD_CMD_MOVTO: mem_store(acc, acc);
					`MCD_CMD_MOVFROM: acc <= cmd_imm ? cmd_data : mem_rd;
					default: skip <= skip;
				endcase
			end
		end
	end
	// Store a byte to the resolved special register, TBLHI excepted and FLAGS taking bits 3:0 only; bit ops choose set or clear value
	task mem_store;
		input [7:0] vset;
		input [7:0] vclr;
		reg [7:0] v;
		begin
			v = (cmd_op == `MCD_CMD_BITCLR) ? vclr : vset;
			if (eff_null) begin
				v = v;
			end else if (eff_lcd) begin
				v = v;
			end else begin
				case (eff_addr)
					`MCD_ADDR_PTR0: ptr0 <= v;
					`MCD_ADDR_PTR1: ptr1 <= v;
					`MCD_ADDR_BANK: bank <= v;
					`MCD_ADDR_ACC: acc <= v;
					`MCD_ADDR_PCL: pc[7:0] <= v;
					`MCD_ADDR_TBLPTR: tblptr <= v;
					`MCD_ADDR_FLAGS: flags[3:0] <= v[3:0];
					default: v = v;
				endcase
			end
		end
	endtask
	// Memory arrays written in their own process to keep one driver each
	always @(posedge clk_sys) begin
		if (state == ST_EXEC && !eff_null && (cmd_op == `MCD_CMD_MOVTO
			|| cmd_op == `MCD_CMD_BITSET || cmd_op == `MCD_CMD_BITCLR)) begin
			if (eff_lcd)
				lcd[eff_addr] <= bit_val(mem_rd);
			else if (eff_addr >= `MCD_ADDR_GP_BASE)
				ram0[eff_addr] <= bit_val(mem_rd);
		end
	end
	function [7:0] bit_val;
		input [7:0] cur;
		begin
			if (cmd_op == `MCD_CMD_BITSET)
				bit_val = cur | (8'h01 << cmd_bit);
			else if (cmd_op == `MCD_CMD_BITCLR)
				bit_val = cur & ~(8'h01 << cmd_bit);
			else
				bit_val = acc;
		end
	endfunction
	// Read data registered at the EXEC edge, ready during DONE; the command word reads back the resolved byte
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (state == ST_EXEC && read) begin
			case (address)
				`MCD_BUS_CMD: readdata <= {24'h00_0000, mem_rd};
				`MCD_BUS_PC: readdata <= {20'h0_0000, pc};
				`MCD_BUS_STAT: readdata <= {22'h00_0000, irq_pend, stk_full, stk_level, 2'b00, 2'b00};
				`MCD_BUS_TBLADDR: readdata <= {20'h0_0000, table_addr};
				`MCD_BUS_ALU: readdata <= {16'h0000, 2'b00, flags, acc};
				default: readdata <= (address < 8'h40) ? {24'h00_0000, sfr_at(address)}
					: `MCD_BUS_ERR_DATA;
			endcase
		end
	end
	function [7:0] sfr_at;
		input [7:0] a;
		begin
			case (a)
				`MCD_ADDR_PTR0: sfr_at = ptr0;
				`MCD_ADDR_PTR1: sfr_at = ptr1;
				`MCD_ADDR_BANK: sfr_at = bank;
				`MCD_ADDR_ACC: sfr_at = acc;
				`MCD_ADDR_PCL: sfr_at = pc[7:0];
				`MCD_ADDR_TBLPTR: sfr_at = tblptr;
				`MCD_ADDR_TBLHI: sfr_at = tblhi;
				`MCD_ADDR_FLAGS: sfr_at = {2'b00, flags};
				default: sfr_at = `MCD_ZERO_BYTE;
			endcase
		end
	endfunction
endmodule

/* File: sim/mcd_checker.sv */
// Concurrent checks on the core block's bus, stack and lookup ports
`timescale 1ns/10ps
module mcd_checker (
	input logic clk_sys,
	input logic rst_n,
	input logic [7:0] address,
	input logic read,
	input logic write,
	input logic [31:0] writedata,
	input logic [31:0] readdata,
	input logic waitrequest,
	input logic irq_ack,
	input logic [11:0] table_addr,
	input logic skip
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	reg cmd_q;
	reg live_q;
	reg [3:0] op_q;
	reg [2:0] ret_hist;
	wire rd_done = read && !waitrequest;
	// Last edge's command, so outputs can be tied to the command that caused them
	always @(posedge clk_sys) begin
		cmd_q <= write && address == 8'h40;
		op_q <= writedata[31:28];
		live_q <= rst_n;
		// Deferred acknowledges come two edges after the return's answer
		ret_hist <= {ret_hist[1:0], write && address == 8'h40 && writedata[31:29] == 3'h1};
	end
	// Taking edge, execute edge, then the answer
	sequence s_wait2;
		waitrequest ##1 waitrequest ##1 !waitrequest;
	endsequence
	a_wait_shape: assert property ($rose(read || write) |-> s_wait2)
		else $error("answer not on third edge");
	a_wait_idle: assert property (!read && !write |-> !waitrequest)
		else $error("wait while idle");
	a_reserved_zero: assert property (rd_done && address >= 8'h24 && address < 8'h40 |->
		readdata == 32'h0000_0000) else $error("reserved place not zero");
	a_byte_wide: assert property (rd_done && address < 8'h40 |->
		readdata[31:8] == 24'h00_0000) else $error("data space wider than a byte");
	a_flag_unused: assert property (rd_done && address == 8'h0a |->
		readdata[7:6] == 2'h0) else $error("unused flag bits set");
	a_ack_single: assert property (irq_ack |=> !irq_ack) else $error("ack too long");
	a_ack_cause: assert property (irq_ack |-> (cmd_q && op_q == 4'h4) || (|ret_hist))
		else $error("ack without interrupt or return");
	a_table_cause: assert property (live_q && !$stable(table_addr) |->
		cmd_q && op_q[3:1] == 3'h4) else $error("lookup address moved alone");
	a_table_ones: assert property (live_q && !$stable(table_addr) && op_q == 4'h9 |->
		table_addr[11:8] == 4'hf) else $error("last page not all ones");
	a_skip_cause: assert property (live_q && !$stable(skip) |->
		cmd_q && op_q == 4'hc) else $error("skip moved without alu");
	c_skip: cover property ($rose(skip));
endmodule
bind mcd_core mcd_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .irq_ack(irq_ack), .table_addr(table_addr), .skip(skip));

/* File: sim/testbench.sv */
// Self-checking bench for the core data memory, stack and flag block
`timescale 1ns/10ps
`include "mcd_defs.vh"
module testbench;
	typedef struct packed {logic [2:0] k; logic [7:0] a; logic [31:0] d;} mcd_row_t;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] address = 8'h00;
	reg read = 1'b0;
	reg write = 1'b0;
	reg [31:0] writedata = 32'h0000_0000;
	wire [31:0] readdata;
	wire waitrequest;
	wire irq_ack;
	wire [11:0] table_addr;
	wire skip;
	int err_total = 0;
	int checks = 0;
	int acks = 0;
	int i;
	int n;
	reg [31:0] q;
	// Kind 0 bus write, 1 bus read, 2 lookup address, 3 data store, 4 data load
	mcd_row_t rows [] = '{
		'{3, 8'h05, 32'h5a}, '{1, 8'h05, 32'h5a}, '{3, 8'h60, 32'ha5}, '{4, 8'h60, 32'ha5},
		'{3, 8'hff, 32'h3c}, '{4, 8'hff, 32'h3c}, '{1, 8'h30, 32'h0}, '{4, 8'h30, 32'h0},
		'{1, 8'h45, 32'hdead_beef}, '{3, 8'h0a, 32'hff}, '{1, 8'h0a, 32'h0f},
		'{3, 8'h01, 32'h61}, '{3, 8'h00, 32'h33}, '{4, 8'h61, 32'h33}, '{4, 8'h00, 32'h33},
		'{3, 8'h01, 32'h00}, '{3, 8'h00, 32'h77}, '{4, 8'h00, 32'h00}, '{1, 8'h01, 32'h00},
		'{3, 8'h03, 32'h70}, '{3, 8'h70, 32'h11}, '{3, 8'h04, 32'h01}, '{3, 8'h02, 32'h44},
		'{4, 8'h70, 32'h11}, '{4, 8'h02, 32'h44}, '{3, 8'h03, 32'h04}, '{4, 8'h02, 32'h01},
		'{3, 8'h04, 32'h00}, '{3, 8'h03, 32'h70}, '{4, 8'h02, 32'h11},
		'{3, 8'h62, 32'h81}, '{0, 8'h40, 32'ha005_0062}, '{4, 8'h62, 32'ha1},
		'{0, 8'h40, 32'hb007_0062}, '{4, 8'h62, 32'h21},
		'{3, 8'h07, 32'hab}, '{0, 8'h41, 32'h5cd}, '{0, 8'h40, 32'h8000_0000},
		'{2, 8'h00, 32'h5ab}, '{0, 8'h40, 32'h9000_0000}, '{2, 8'h00, 32'hfab},
		'{3, 8'h0a, 32'h05}, '{0, 8'h41, 32'h123}, '{0, 8'h40, 32'h1000_0456},
		'{1, 8'h41, 32'h456}, '{1, 8'h42, 32'h10}, '{0, 8'h40, 32'h2000_0000},
		'{1, 8'h41, 32'h123}, '{1, 8'h42, 32'h00}, '{1, 8'h0a, 32'h05},
		'{3, 8'h0a, 32'h00}, '{0, 8'h40, 32'h5000_0000}, '{1, 8'h0a, 32'h10},
		'{0, 8'h40, 32'h7000_0000}, '{1, 8'h0a, 32'h30}, '{3, 8'h0a, 32'h0f},
		'{1, 8'h0a, 32'h3f}, '{0, 8'h40, 32'h5000_0000}, '{1, 8'h0a, 32'h1f},
		'{0, 8'h40, 32'h6000_0000}, '{1, 8'h0a, 32'h0f}};
	mcd_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq_ack(irq_ack), .table_addr(table_addr), .skip(skip));
	always #25 clk_sys = ~clk_sys;
	// Acknowledge pulses last one cycle, so a running count catches every one
	always @(posedge clk_sys) begin
		if (irq_ack === 1'b1) acks <= acks + 1;
	end
	task fail(input string m);
		err_total++;
		$display("FAIL %0t %s", $time, m);
	endtask
	task chk_data(input [31:0] g, input [31:0] e);
		checks++;
		if (g !== e) fail($sformatf("data %h expected %h", g, e));
	endtask
	task chk_tab(input [11:0] g, input [11:0] e);
		checks++;
		if (g !== e) fail($sformatf("lookup %h expected %h", g, e));
	endtask
	// Hold the request until the rising edge that samples waitrequest low, then release
	task bus(input bit wr, input [7:0] a, input [31:0] d, output [31:0] rd);
		int w;
		w = 0;
		@(posedge clk_sys);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		do begin
			@(posedge clk_sys);
			w++;
		end while (waitrequest !== 1'b0 && w < 20);
		if (w >= 20) fail("bus answer missing");
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		bus(1'b1, a, d, q);
	endtask
	task rdchk(input [7:0] a, input [31:0] e);
		bus(1'b0, a, 32'h0000_0000, q);
		chk_data(q, e);
	endtask
	task cmd(input [3:0] op, input [11:0] t);
		wr(8'h40, {op, 16'h0000, t});
	endtask
	// put and get reach data space through the accumulator: load immediate, then store
	task put(input [7:0] a, input [7:0] v);
		wr(8'h40, {8'he1, 8'h00, v, 8'h00});
		wr(8'h40, {24'hd0_0000, a});
	endtask
	task get(input [7:0] a, input [7:0] e);
		wr(8'h40, {24'he0_0000, a});
		bus(1'b0, 8'h44, 32'h0000_0000, q);
		chk_data({24'h00_0000, q[7:0]}, {24'h00_0000, e});
	endtask
	// Preset flags and accumulator, run one immediate operation, read both back
	task alu(input [7:0] pre, input [3:0] op, input [7:0] av, input [7:0] bv, input [15:0] e);
		put(8'h0a, pre);
		wr(8'h40, {8'he1, 8'h00, av, 8'h00});
		wr(8'h40, {8'hc1, op, 4'h0, bv, 8'h05});
		rdchk(8'h44, {16'h0000, e});
		@(negedge clk_sys);
		chk_data({31'h0, skip}, {31'h0, e[7:0] == 8'h00});
	endtask
	task end_test(input string s);
		$display("test %s done", s);
	endtask
	task stop_test;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Runs far past the expected few hundred cycles (under a thousand) before giving up
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail("run timed out");
		stop_test;
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdchk(8'h42, 32'h0);
		rdchk(8'h0a, 32'h0);
		end_test("reset");
		foreach (rows[r]) begin
			if (rows[r].k == 3'd2) begin
				@(negedge clk_sys);
				chk_tab(table_addr, rows[r].d[11:0]);
			end else if (rows[r].k == 3'd0)
				wr(rows[r].a, rows[r].d);
			else if (rows[r].k == 3'd3)
				put(rows[r].a, rows[r].d[7:0]);
			else if (rows[r].k == 3'd4)
				get(rows[r].a, rows[r].d[7:0]);
			else
				rdchk(rows[r].a, rows[r].d);
		end
		end_test("rows");
		alu(8'h00, `MCD_OP_ADD, 8'h7f, 8'h01, 16'h0a80);
		alu(8'h00, `MCD_OP_ADD, 8'hff, 8'h01, 16'h0700);
		alu(8'h00, `MCD_OP_SUB, 8'h05, 8'h05, 16'h0700);
		alu(8'h00, `MCD_OP_SUB, 8'h00, 8'h01, 16'h00ff);
		alu(8'h01, `MCD_OP_ADC, 8'h01, 8'h01, 16'h0003);
		alu(8'h00, `MCD_OP_AND, 8'hf0, 8'h0f, 16'h0400);
		alu(8'h00, `MCD_OP_RLC, 8'h81, 8'h00, 16'h0102);
		end_test("alu");
		wr(8'h41, 32'h321);
		n = acks;
		cmd(`MCD_CMD_IRQ, 12'h004);
		@(negedge clk_sys);
		chk_data(acks - n, 32'h1);
		rdchk(8'h41, 32'h004);
		cmd(`MCD_CMD_INTERRUPT_RETURN, 12'h000);
		rdchk(8'h41, 32'h321);
		wr(8'h41, 32'h100);
		for (i = 0; i < 9; i++) cmd(`MCD_CMD_CALL, 12'(12'h200 + i));
		rdchk(8'h42, 32'h180);
		for (i = 7; i >= 0; i--) begin
			cmd(`MCD_CMD_RET, 12'h000);
			rdchk(8'h41, 32'(32'h200 + i));
		end
		cmd(`MCD_CMD_RET, 12'h000);
		rdchk(8'h41, 32'h200);
		for (i = 0; i < 8; i++) cmd(`MCD_CMD_CALL, 12'(12'h300 + i));
		n = acks;
		cmd(`MCD_CMD_IRQ, 12'h008);
		rdchk(8'h42, 32'h380);
		chk_data(acks - n, 32'h0);
		cmd(`MCD_CMD_RET, 12'h000);
		// Deferred acknowledge waits for the idle state after the return
		repeat (3) @(negedge clk_sys);
		chk_data(acks - n, 32'h1);
		rdchk(8'h41, 32'h306);
		end_test("stack");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdchk(8'h42, 32'h0);
		rdchk(8'h0a, 32'h0);
		end_test("second reset");
		stop_test;
	end
endmodule
